// >>> hdl/sbt_sync2.sv
module sbt_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   // ----------------------------------------------------------------
   // two-stage synchroniser
   // ----------------------------------------------------------------
   // no reset: these stages only carry a level across, and a reset
   // here would have to come from the very domain being crossed
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk_in) begin
      meta_q <= d_in;
   end

   always_ff @(posedge clk_in) begin
      sync_q <= meta_q;
   end

   assign q_out = sync_q;
endmodule

// >>> hdl/sbt_tap.sv
module sbt_tap (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic tck_in,
   input wire sbt_pkg::sbt_scan_in_t scan_in,
   input wire logic [sbt_pkg::BSR_LEN-1:0] ring_in,
   output sbt_pkg::sbt_scan_out_t scan_out,
   output logic sram_hiz_out,
   output logic tap_in_reset_out
);
   import sbt_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic tck_rst;
   logic [BSR_LEN-1:0] ring_sync;
   sbt_state_t state_q;
   sbt_state_t state_d;
   logic [IR_LEN-1:0] ir_shift_q;
   logic [IR_LEN-1:0] ir_q;
   logic bypass_q;
   logic [ID_LEN-1:0] id_q;
   logic [BSR_LEN-1:0] bsr_q;
   sbt_dr_sel_t dr_sel;
   logic dr_lsb;
   logic tdo_q;
   logic tdo_oe_q;
   logic hiz_tck_q;
   logic tlr_tck_q;
   logic hiz_sync;
   logic tlr_sync;
   logic hiz_q;
   logic tlr_q;
   logic tms;
   logic tdi;

   // ----------------------------------------------------------------
   // link-side reset and pin capture
   // ----------------------------------------------------------------
   // the system reset reaches the test clock domain through a
   // synchroniser; it only acts while the test clock runs
   sbt_sync2 #(
      .W(1)
   ) u_rst_sync (
      .clk_in(tck_in),
      .d_in(srst_in),
      .q_out(tck_rst)
   );

   // ring balls are asynchronous to the test clock; values captured
   // are two test clocks old, and a moving ball reads as either level
   sbt_sync2 #(
      .W(BSR_LEN)
   ) u_ring_sync (
      .clk_in(tck_in),
      .d_in(ring_in),
      .q_out(ring_sync)
   );

   // scan pins arrive aligned to the test clock, so no synchroniser
   assign tms = scan_in.tms;
   assign tdi = scan_in.tdi;

   // ----------------------------------------------------------------
   // controller state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_TEST_LOGIC_RESET: begin
            state_d = tms ? ST_TEST_LOGIC_RESET : ST_RUN_TEST_IDLE;
         end
         ST_RUN_TEST_IDLE: begin
            state_d = tms ? ST_SELECT_DR : ST_RUN_TEST_IDLE;
         end
         ST_SELECT_DR: begin
            state_d = tms ? ST_SELECT_IR : ST_CAPTURE_DR;
         end
         ST_CAPTURE_DR: begin
            state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         end
         ST_SHIFT_DR: begin
            state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         end
         ST_EXIT1_DR: begin
            state_d = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
         end
         ST_PAUSE_DR: begin
            state_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
         end
         ST_EXIT2_DR: begin
            state_d = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
         end
         ST_UPDATE_DR: begin
            state_d = tms ? ST_SELECT_DR : ST_RUN_TEST_IDLE;
         end
         ST_SELECT_IR: begin
            // a run of high TMS reaches test logic reset by its fifth bit, through this state unless it starts in reset
            state_d = tms ? ST_TEST_LOGIC_RESET : ST_CAPTURE_IR;
         end
         ST_CAPTURE_IR: begin
            state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         end
         ST_SHIFT_IR: begin
            state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         end
         ST_EXIT1_IR: begin
            state_d = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
         end
         ST_PAUSE_IR: begin
            state_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
         end
         ST_EXIT2_IR: begin
            state_d = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
         end
         ST_UPDATE_IR: begin
            state_d = tms ? ST_SELECT_DR : ST_RUN_TEST_IDLE;
         end
      endcase
   end

   always_ff @(posedge tck_in) begin
      if (tck_rst) begin
         state_q <= ST_TEST_LOGIC_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------
   // shift stage: parallel capture, then serial load toward the LSB
   always_ff @(posedge tck_in) begin
      if (tck_rst) begin
         ir_shift_q <= IR_RESET_VAL;
      end else begin
         unique case (state_q)
            ST_CAPTURE_IR: begin
               ir_shift_q <= IR_CAPTURE_VAL;
            end
            ST_SHIFT_IR: begin
               ir_shift_q <= {tdi, ir_shift_q[IR_LEN-1:1]};
            end
            default: begin
               ir_shift_q <= ir_shift_q;
            end
         endcase
      end
   end

   // active instruction: changes only at Update-IR or test logic reset
   always_ff @(posedge tck_in) begin
      if (tck_rst) begin
         ir_q <= IR_RESET_VAL;
      end else if (state_q == ST_TEST_LOGIC_RESET) begin
         ir_q <= IR_RESET_VAL;
      end else if (state_q == ST_UPDATE_IR) begin
         ir_q <= ir_shift_q;
      end
   end

   // ----------------------------------------------------------------
   // instruction decode
   // ----------------------------------------------------------------
   // reserved codes fall back to the bypass path so a stray load still
   // leaves the chain one bit long
   always_comb begin
      unique case (ir_q)
         INS_IDCODE: begin
            dr_sel = DR_IDCODE;
         end
         INS_EXTEST, INS_SAMPLE, INS_SAMPLE_Z: begin
            dr_sel = DR_BOUNDARY;
         end
         INS_BYPASS, INS_RSVD_A, INS_RSVD_B, INS_RSVD_C: begin
            dr_sel = DR_BYPASS;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // data registers
   // ----------------------------------------------------------------
   always_ff @(posedge tck_in) begin
      if (tck_rst) begin
         bypass_q <= BYPASS_CLEAR_VAL;
      end else if (dr_sel == DR_BYPASS) begin
         if (state_q == ST_CAPTURE_DR) begin
            bypass_q <= BYPASS_CLEAR_VAL;
         end else if (state_q == ST_SHIFT_DR) begin
            bypass_q <= tdi;
         end
      end
   end

   always_ff @(posedge tck_in) begin
      if (tck_rst) begin
         id_q <= ID_CODE_VAL;
      end else if (dr_sel == DR_IDCODE) begin
         if (state_q == ST_CAPTURE_DR) begin
            id_q <= ID_CODE_VAL;
         end else if (state_q == ST_SHIFT_DR) begin
            id_q <= {tdi, id_q[ID_LEN-1:1]};
         end
      end
   end

   // no preload stage behind the shift cells: the ring is only observed
   always_ff @(posedge tck_in) begin
      if (tck_rst) begin
         bsr_q <= BSR_RESET_VAL;
      end else if (dr_sel == DR_BOUNDARY) begin
         if (state_q == ST_CAPTURE_DR) begin
            bsr_q <= ring_sync;
         end else if (state_q == ST_SHIFT_DR) begin
            bsr_q <= {tdi, bsr_q[BSR_LEN-1:1]};
         end
      end
   end

   always_comb begin
      unique case (dr_sel)
         DR_IDCODE: begin
            dr_lsb = id_q[0];
         end
         DR_BOUNDARY: begin
            dr_lsb = bsr_q[0];
         end
         DR_BYPASS: begin
            dr_lsb = bypass_q;
         end
         default: begin
            dr_lsb = bypass_q;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // serial output on the falling edge
   // ----------------------------------------------------------------
   // half a test clock after each rise, so the far end samples a
   // settled bit on its next rising edge
   always_ff @(negedge tck_in) begin
      if (tck_rst) begin
         tdo_oe_q <= 1'b0;
      end else begin
         tdo_oe_q <= (state_q == ST_SHIFT_DR) || (state_q == ST_SHIFT_IR);
      end
   end

   always_ff @(negedge tck_in) begin
      if (tck_rst) begin
         tdo_q <= 1'b0;
      end else if (state_q == ST_SHIFT_IR) begin
         tdo_q <= ir_shift_q[0];
      end else if (state_q == ST_SHIFT_DR) begin
         tdo_q <= dr_lsb;
      end
   end

   assign scan_out.tdo = tdo_q;
   assign scan_out.tdo_oe = tdo_oe_q;

   // ----------------------------------------------------------------
   // status levels toward the memory clock
   // ----------------------------------------------------------------
   // registered before crossing so no decode glitch reaches the core
   always_ff @(posedge tck_in) begin
      if (tck_rst) begin
         hiz_tck_q <= 1'b0;
      end else begin
         hiz_tck_q <= (ir_q == INS_EXTEST) || (ir_q == INS_SAMPLE_Z);
      end
   end

   always_ff @(posedge tck_in) begin
      if (tck_rst) begin
         tlr_tck_q <= 1'b1;
      end else begin
         tlr_tck_q <= (state_q == ST_TEST_LOGIC_RESET);
      end
   end

   sbt_sync2 #(
      .W(1)
   ) u_hiz_sync (
      .clk_in(core_clk_in),
      .d_in(hiz_tck_q),
      .q_out(hiz_sync)
   );

   sbt_sync2 #(
      .W(1)
   ) u_tlr_sync (
      .clk_in(core_clk_in),
      .d_in(tlr_tck_q),
      .q_out(tlr_sync)
   );

   // ----------------------------------------------------------------
   // memory clock side
   // ----------------------------------------------------------------
   // a port reset only returns the instruction to identification read,
   // which never floats the outputs, so memory traffic goes on
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         hiz_q <= 1'b0;
      end else begin
         hiz_q <= hiz_sync;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         tlr_q <= 1'b1;
      end else begin
         tlr_q <= tlr_sync;
      end
   end

   assign sram_hiz_out = hiz_q;
   assign tap_in_reset_out = tlr_q;

endmodule

// >>> inc/sbt_pkg.sv
package sbt_pkg;

   // ----------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------
   localparam int IR_LEN = 3;
   localparam logic [IR_LEN-1:0] INS_EXTEST = 3'h0;
   localparam logic [IR_LEN-1:0] INS_IDCODE = 3'h1;
   localparam logic [IR_LEN-1:0] INS_SAMPLE_Z = 3'h2;
   localparam logic [IR_LEN-1:0] INS_RSVD_A = 3'h3;
   localparam logic [IR_LEN-1:0] INS_SAMPLE = 3'h4;
   localparam logic [IR_LEN-1:0] INS_RSVD_B = 3'h5;
   localparam logic [IR_LEN-1:0] INS_RSVD_C = 3'h6;
   localparam logic [IR_LEN-1:0] INS_BYPASS = 3'h7;
   // pattern loaded into the two low bits at capture, upper bit cleared
   localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 3'h1;
   localparam logic [IR_LEN-1:0] IR_RESET_VAL = INS_IDCODE;

   // ----------------------------------------------------------------
   // data registers
   // ----------------------------------------------------------------
   localparam int ID_LEN = 32;
   // identification value is arbitrary; bit 0 kept high as the scan convention asks
   localparam logic [ID_LEN-1:0] ID_CODE_VAL = 32'h0a5a_0001;
   localparam int BSR_LEN = 16;
   localparam logic [BSR_LEN-1:0] BSR_RESET_VAL = 16'h0000;
   localparam logic BYPASS_CLEAR_VAL = 1'b0;

   // ----------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_TEST_LOGIC_RESET,
      ST_RUN_TEST_IDLE,
      ST_SELECT_DR,
      ST_CAPTURE_DR,
      ST_SHIFT_DR,
      ST_EXIT1_DR,
      ST_PAUSE_DR,
      ST_EXIT2_DR,
      ST_UPDATE_DR,
      ST_SELECT_IR,
      ST_CAPTURE_IR,
      ST_SHIFT_IR,
      ST_EXIT1_IR,
      ST_PAUSE_IR,
      ST_EXIT2_IR,
      ST_UPDATE_IR
   } sbt_state_t;

   typedef enum logic [1:0] {
      DR_BYPASS,
      DR_IDCODE,
      DR_BOUNDARY
   } sbt_dr_sel_t;

   // ----------------------------------------------------------------
   // scan pin groups
   // ----------------------------------------------------------------
   typedef struct packed {
      logic tms;
      logic tdi;
   } sbt_scan_in_t;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } sbt_scan_out_t;

endpackage

// >>> test/sbt_ctl_model.sv
module sbt_ctl_model (
   output logic tck_out,
   output sbt_pkg::sbt_scan_in_t pins_out,
   input wire sbt_pkg::sbt_scan_out_t pins_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import sbt_pkg::*;
   // clock rests low between frames, as on an unused port
   initial begin
      tck_out = 1'b0;
      pins_out = '1;
   end
   // one 64 ns period; the answer is read well after the falling edge
   task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
      pins_out <= {tms, tdi};
      #16 tck_out = 1'b1;
      #32 tck_out = 1'b0;
      // nothing holds the released line, so show it flipped to expose a stale read
      #16 tdo = pins_in.tdo_oe ? pins_in.tdo : ~pins_in.tdo;
      oe = pins_in.tdo_oe;
   endtask
endmodule

// >>> test/sbt_tap_assertions.sv
module sbt_tap_assertions (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic tck_in,
   input wire sbt_pkg::sbt_scan_in_t scan_in,
   input wire logic [sbt_pkg::BSR_LEN-1:0] ring_in,
   input wire sbt_pkg::sbt_scan_out_t scan_out,
   input wire logic sram_hiz_out,
   input wire logic tap_in_reset_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import sbt_pkg::*;
   // ----------
   // idle tracking
   // ----------
   // outputs may still settle two core edges after a fall, hence the margin of four
   logic [3:0] idle_q;
   always_ff @(posedge core_clk_in) begin
      if (srst_in || tck_in) begin
         idle_q <= 4'h0;
      end else if (idle_q != 4'hf) begin
         idle_q <= idle_q + 4'h1;
      end
   end
   // ----------
   // core clock domain
   // ----------
   tdo_fall_only_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
      tck_in && $past(tck_in) |-> $stable(scan_out))
      else $error("scan output moved while test clock high");
   oe_off_reset_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
      tap_in_reset_out && $past(tap_in_reset_out) |-> !scan_out.tdo_oe)
      else $error("output driven in reset state");
   hold_while_idle_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
      idle_q >= 4'h4 |-> $stable(sram_hiz_out) && $stable(tap_in_reset_out))
      else $error("core flags moved with test clock stopped");
   // ----------
   // test clock domain
   // ----------
   tms_reset_a: assert property (@(posedge tck_in) disable iff (srst_in)
      scan_in.tms [*8] |-> tap_in_reset_out && !sram_hiz_out)
      else $error("held mode select did not reset the port");
   leave_reset_a: assert property (@(posedge tck_in) disable iff (srst_in)
      !scan_in.tms [*6] |-> !tap_in_reset_out)
      else $error("port stuck in reset with mode select low");
   shift_entry_a: assert property (@(posedge tck_in) disable iff (srst_in)
      $rose(scan_out.tdo_oe) |-> !$past(scan_in.tms))
      else $error("output enabled without a shift entry");
   shift_exit_a: assert property (@(posedge tck_in) disable iff (srst_in)
      $fell(scan_out.tdo_oe) |-> $past(scan_in.tms))
      else $error("output released without a shift exit");
   shift_hold_a: assert property (@(posedge tck_in) disable iff (srst_in)
      scan_out.tdo_oe && !scan_in.tms |=> scan_out.tdo_oe)
      else $error("shift left with mode select low");
endmodule

bind sbt_tap sbt_tap_assertions sbt_tap_assertions_inst (
   .core_clk_in(core_clk_in),
   .srst_in(srst_in),
   .tck_in(tck_in),
   .scan_in(scan_in),
   .ring_in(ring_in),
   .scan_out(scan_out),
   .sram_hiz_out(sram_hiz_out),
   .tap_in_reset_out(tap_in_reset_out)
);

// >>> test/test_sbt_tap.sv
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_sbt_tap;
   timeunit 1ns;
   timeprecision 1ps;
   import sbt_pkg::*;
   // ----------
   // clocks and instances
   // ----------
   logic core_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic tck;
   logic [BSR_LEN-1:0] ring = '0;
   sbt_scan_in_t pins;
   sbt_scan_out_t sout;
   logic hiz;
   logic trst;
   int error_cnt = 0;
   int n_checks = 0;
   initial begin
      forever #10 core_clk_in = ~core_clk_in;
   end
   sbt_tap sbt_tap_inst (
      .core_clk_in(core_clk_in),
      .srst_in(srst_in),
      .tck_in(tck),
      .scan_in(pins),
      .ring_in(ring),
      .scan_out(sout),
      .sram_hiz_out(hiz),
      .tap_in_reset_out(trst)
   );
   sbt_ctl_model sbt_ctl_model_inst (.tck_out(tck), .pins_out(pins), .pins_in(sout));
   // ----------
   // scan helpers
   // ----------
   task automatic st(input logic tms, input logic tdi, output logic o, output logic oe);
      sbt_ctl_model_inst.step(tms, tdi, o, oe);
   endtask
   // core flags lag the test clock by a few core edges
   task automatic idle();
      repeat (6) @(posedge core_clk_in);
   endtask
   task automatic upd();
      logic o;
      logic oe;
      st(1'b1, 1'b1, o, oe);
      st(1'b0, 1'b1, o, oe);
   endtask
   // from idle: capture, then n shifts; bit 0 is visible before the first shift
   task automatic scan(input bit ir, input int n, input logic [47:0] pat,
                       output logic [47:0] got);
      logic o;
      logic oe;
      got = '0;
      st(1'b1, 1'b1, o, oe);
      if (ir) st(1'b1, 1'b1, o, oe);
      st(1'b0, 1'b1, o, oe);
      st(1'b0, 1'b1, o, oe);
      got[0] = o;
      `CHK("oe_shift", 1'b1, oe)
      for (int i = 1; i <= n; i++) begin
         st(i == n, pat[i-1], o, oe);
         if (i < n) got[i] = o;
      end
      `CHK("oe_exit", 1'b0, oe)
   endtask
   task automatic load_ir(input logic [2:0] c, input logic prev);
      logic [47:0] got;
      logic o;
      logic oe;
      scan(1'b1, 3, {45'h0, c}, got);
      `CHK("ir_capture", 3'b001, got[2:0])
      st(1'b0, 1'b1, o, oe);
      st(1'b0, 1'b1, o, oe);
      idle();
      `CHK("hiz_pause", prev, hiz)
      st(1'b1, 1'b1, o, oe);
      upd();
      st(1'b0, 1'b1, o, oe);
      idle();
      `CHK("hiz_update", (c == INS_EXTEST) || (c == INS_SAMPLE_Z), hiz)
      `CHK("tap_reset_flag", 1'b0, trst)
   endtask
   // ----------
   // scenarios
   // ----------
   task automatic t_reset();
      logic o;
      logic oe;
      repeat (3) @(posedge core_clk_in);
      repeat (4) st(1'b1, 1'b1, o, oe);
      @(posedge core_clk_in) srst_in <= 1'b0;
      repeat (3) st(1'b1, 1'b1, o, oe);
      idle();
      `CHK("oe_power_up", 1'b0, oe)
      `CHK("tap_reset_flag", 1'b1, trst)
      `CHK("hiz_power_up", 1'b0, hiz)
      st(1'b0, 1'b1, o, oe);
   endtask
   // every implemented code; each data scan runs twice so the second capture
   // must overwrite what the first one shifted in
   task automatic t_codes();
      logic [47:0] got;
      logic [47:0] exp;
      logic [47:0] pat;
      logic [2:0] c;
      logic prev;
      int len;
      pat = 48'h9c5e_3b1d_a6f2;
      prev = 1'b0;
      for (int k = 0; k < 8; k++) begin
         c = k[2:0];
         if ((c == INS_RSVD_A) || (c == INS_RSVD_B) || (c == INS_RSVD_C)) begin
            continue;
         end
         @(posedge core_clk_in) ring <= 16'h5a30 ^ 16'(k);
         load_ir(c, prev);
         prev = (c == INS_EXTEST) || (c == INS_SAMPLE_Z);
         len = (c == INS_IDCODE) ? ID_LEN : ((c == INS_EXTEST) || (c == INS_SAMPLE) ||
            (c == INS_SAMPLE_Z)) ? BSR_LEN : 1;
         exp = (c == INS_IDCODE) ? 48'(ID_CODE_VAL) : (len == 1) ?
            48'(BYPASS_CLEAR_VAL) : 48'(ring);
         exp = (exp | (pat << len)) & ((48'h1 << (len + 4)) - 48'h1);
         repeat (2) begin
            scan(1'b0, len + 4, pat, got);
            `CHK("dr_scan", exp, got)
            upd();
         end
      end
   endtask
   task automatic t_tms_reset();
      logic [47:0] got;
      logic o;
      logic oe;
      load_ir(INS_SAMPLE_Z, 1'b0);
      st(1'b1, 1'b1, o, oe);
      st(1'b0, 1'b1, o, oe);
      st(1'b0, 1'b1, o, oe);
      `CHK("oe_in_shift", 1'b1, oe)
      repeat (8) st(1'b1, 1'b1, o, oe);
      idle();
      `CHK("oe_after_reset", 1'b0, oe)
      `CHK("tap_reset_flag", 1'b1, trst)
      `CHK("hiz_after_reset", 1'b0, hiz)
      st(1'b0, 1'b1, o, oe);
      scan(1'b0, ID_LEN, '0, got);
      `CHK("id_after_reset", 48'(ID_CODE_VAL), got)
      upd();
   endtask
   task automatic end_of_test();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      t_reset();
      t_codes();
      t_tms_reset();
      end_of_test();
   end
   // the scans take about 27 us; over seven times that means a hang
   initial begin
      #200us;
      error_cnt++;
      end_of_test();
   end
endmodule
